/* File: inc/pmm_cfg.svh */
// constants and offsets for the program memory mode block
`ifndef PMM_CFG_SVH
`define PMM_CFG_SVH
// ==========================================================
// register map
`define OFS_CFG      4'h0
`define OFS_BUSCTL   4'h4
`define OFS_STATUS   4'h8
// ==========================================================
// configuration byte fields
`define CB_WAIT_DIS  7
`define CB_WIDTH     6
`define CB_MODE_HI   5
`define CB_MODE_LO   4
`define CB_SHIFT     3
`define CB_IMPL      8'hf8
`define CB_ERASED    8'hf8
`define MODE_ONCHIP  2'b11
`define MODE_A12     2'b10
`define MODE_A16     2'b01
`define MODE_A20     2'b00
`define MASK_A12     20'h00fff
`define MASK_A16     20'h0ffff
`define MASK_A20     20'hfffff
// ==========================================================
// bus control and timing
`define BC_WAIT_HI   5
`define BC_WAIT_LO   4
`define BC_RESET     2'h3
`define TCY_CLKS     8'h04
`define ACC_CLKS     8'h04
`define PMEM_TOP     21'h1fffff
`define FLASH_TOP    21'h010000
`define NOP_WORD     16'h0000
`endif

/* File: inc/pmm_pkg.sv */
// types shared by the program memory mode block
package pmm_pkg;
    typedef logic [20:0] paddr_t;
    typedef logic [19:0] xaddr_t;
    typedef logic [15:0] word_t;
    typedef logic [7:0]  cbyte_t;
    typedef enum logic [1:0] {
        M_IDLE  = 2'b00,
        M_FLASH = 2'b01,
        M_EXT   = 2'b11,
        M_RESP  = 2'b10
    } main_state_t;
    typedef enum logic [1:0] {
        E_IDLE = 2'b00,
        E_ACC  = 2'b01,
        E_WAIT = 2'b11,
        E_END  = 2'b10
    } ext_state_t;
endpackage

/* File: hw/pin_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clk) begin
        s1_r <= din;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    // only stages two and three are compared; stage one stays private
    always_ff @(posedge clk) begin
        if (rst) begin
            dout <= '0;
        end else if (s2_r == s3_r) begin
            dout <= s3_r;
        end
    end
endmodule

/* File: hw/ext_bus_cycle.sv */
// one external bus cycle with optional table-op wait states
`timescale 1ns/1ps
`include "pmm_cfg.svh"
module ext_bus_cycle #(
    parameter logic [7:0] ACC = `ACC_CLKS,
    parameter logic [7:0] TCY = `TCY_CLKS
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic       table_op,
    input  wire logic       write_op,
    input  wire logic       wait_en,
    input  wire logic [1:0] wait_sel,
    output logic            busy,
    output logic            done,
    output logic            ce_n,
    output logic            rd_n,
    output logic            wr_n
);
    import pmm_pkg::*;
    ext_state_t st_r;
    logic [7:0] cnt_r;
    logic       wr_r;
    logic       tw_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r  <= E_IDLE;
            cnt_r <= 8'h00;
            wr_r  <= 1'b0;
            tw_r  <= 1'b0;
        end else begin
            unique case (st_r)
                E_IDLE: begin
                    if (start) begin
                        st_r  <= E_ACC;
                        cnt_r <= ACC - 8'h01;
                        wr_r  <= write_op;
                        // delay follows only table ops
                        tw_r  <= table_op & wait_en & (wait_sel != 2'h0);
                    end
                end
                E_ACC: begin
                    if (cnt_r != 8'h00) begin
                        cnt_r <= cnt_r - 8'h01;
                    end else if (tw_r) begin
                        st_r  <= E_WAIT;
                        // whole instruction cycles
                        cnt_r <= 8'(wait_sel * TCY) - 8'h01;
                    end else begin
                        st_r <= E_END;
                    end
                end
                E_WAIT: begin
                    if (cnt_r != 8'h00) begin
                        cnt_r <= cnt_r - 8'h01;
                    end else begin
                        st_r <= E_END;
                    end
                end
                E_END: begin
                    st_r <= E_IDLE;
                end
            endcase
        end
    end

    assign busy = (st_r != E_IDLE);
    assign done = (st_r == E_END);
    assign ce_n = !(st_r == E_ACC || st_r == E_WAIT);
    assign rd_n = ce_n | wr_r;
    assign wr_n = !(st_r == E_ACC) | !wr_r;

    // ==========================================================
    // checks
    // the end state adds one cycle beyond the access itself
    localparam int ACC_DONE = ACC + 1;
    logic [7:0] len_r;
    always_ff @(posedge clk) begin
        if (rst || !busy) begin
            len_r <= 8'h00;
        end else begin
            len_r <= len_r + 8'h01;
        end
    end

    a_cycle_length: assert property (@(posedge clk) disable iff (rst)
        done |-> len_r == ACC + (tw_r ? 8'(wait_sel * TCY) : 8'h00))
        else $error("external cycle length wrong");
    a_wait_disabled: assert property (@(posedge clk) disable iff (rst)
        (start && !busy && !wait_en) |-> ##ACC_DONE done)
        else $error("wait states added while disabled");
    c_table_wait: cover property (@(posedge clk) disable iff (rst)
        done && tw_r && wait_sel == 2'h3);
endmodule

/* File: hw/program_memory_mode_config.sv */
// program memory mode selection and external program bus control
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pmm_cfg.svh"
module program_memory_mode_config #(
    parameter pmm_pkg::paddr_t FLASH_TOP = `FLASH_TOP,
    parameter logic [7:0]      ACC       = `ACC_CLKS,
    parameter logic [7:0]      TCY       = `TCY_CLKS
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [3:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    input  wire logic             pkg_large,
    input  wire pmm_pkg::cbyte_t  cfg_nv,
    input  wire logic             cfg_nv_locked,
    output logic                  cfg_prog,
    output pmm_pkg::cbyte_t       cfg_prog_data,
    input  wire logic             fetch_req,
    input  wire logic             fetch_table,
    input  wire logic             fetch_write,
    input  wire pmm_pkg::paddr_t  fetch_addr,
    input  wire pmm_pkg::word_t   fetch_wdata,
    output logic                  fetch_done,
    output pmm_pkg::word_t        fetch_rdata,
    output logic                  flash_rd,
    output pmm_pkg::paddr_t       flash_addr,
    input  wire pmm_pkg::word_t   flash_rdata,
    output logic                  ext_bus_active,
    output pmm_pkg::xaddr_t       ext_addr,
    output pmm_pkg::xaddr_t       ext_addr_oe,
    output pmm_pkg::word_t        ext_data_out,
    output logic                  ext_data_oe,
    input  wire pmm_pkg::word_t   ext_data_in,
    output logic                  ext_ce_n,
    output logic                  ext_rd_n,
    output logic                  ext_wr_n
);
    import pmm_pkg::*;

    // ==========================================================
    // configuration caught at reset
    cbyte_t      cfg_act_r;
    logic        large_r;
    logic        prog_done_r;
    logic [1:0]  memory_mode_select;
    logic        data_width_select;
    logic        address_offset_enable;
    logic        wait_enable;
    logic        onchip_only_mode;
    logic        extended_memory_mode;

    // held in reset so the settings never move while code runs
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_act_r <= cfg_nv & `CB_IMPL;
            large_r   <= pkg_large;
        end
    end

    assign memory_mode_select =
        cfg_act_r[`CB_MODE_HI:`CB_MODE_LO];
    assign data_width_select     = cfg_act_r[`CB_WIDTH];
    assign address_offset_enable = cfg_act_r[`CB_SHIFT];
    assign wait_enable           = !cfg_act_r[`CB_WAIT_DIS];
    // small package never leaves on-chip mode
    assign onchip_only_mode =
        (memory_mode_select == `MODE_ONCHIP) | !large_r;
    assign extended_memory_mode = !onchip_only_mode;

    function automatic xaddr_t width_mask(input logic [1:0] m);
        unique case (m)
            `MODE_A12: width_mask = `MASK_A12;
            `MODE_A16: width_mask = `MASK_A16;
            `MODE_A20: width_mask = `MASK_A20;
            default:   width_mask = '0;
        endcase
    endfunction

    // ==========================================================
    // register bus slave
    logic       ack_r;
    logic [1:0] wait_sel_r;
    logic       req;
    logic       hit_cfg;
    logic       hit_bc;
    logic       hit_st;
    logic       rd_first;
    logic       wr_take;
    logic [7:0] status_word;

    assign req     = avs_read | avs_write;
    assign hit_cfg = (avs_address == `OFS_CFG);
    assign hit_bc  = (avs_address == `OFS_BUSCTL);
    assign hit_st  = (avs_address == `OFS_STATUS);
    // fixed one wait cycle keeps the decode off the critical path
    assign avs_waitrequest = req & !ack_r;
    // reads load early so data stands when waitrequest drops;
    // writes land only at that edge, as the master expects
    assign rd_first = avs_read & !ack_r;
    assign wr_take  = avs_write & ack_r;
    assign status_word = {cfg_act_r[`CB_WAIT_DIS:`CB_SHIFT],
                          prog_done_r | cfg_nv_locked,
                          large_r,
                          onchip_only_mode};

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & !ack_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (rd_first) begin
            avs_readdata <= 32'h00000000;
            if (hit_cfg) begin
                // unimplemented low bits read zero
                avs_readdata[7:0] <= cfg_nv & `CB_IMPL;
            end else if (hit_bc) begin
                avs_readdata[`BC_WAIT_HI:`BC_WAIT_LO] <= wait_sel_r;
            end else if (hit_st) begin
                avs_readdata[7:0] <= status_word;
            end
        end
    end

    // one programming pulse per reset while the part is unlocked
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_prog      <= 1'b0;
            cfg_prog_data <= `CB_ERASED;
            prog_done_r   <= 1'b0;
        end else begin
            cfg_prog <= 1'b0;
            if (wr_take && hit_cfg && !prog_done_r &&
                !cfg_nv_locked) begin
                cfg_prog      <= 1'b1;
                cfg_prog_data <= avs_writedata[7:0] & `CB_IMPL;
                prog_done_r   <= 1'b1;
            end
        end
    end

    // bus control is frozen in on-chip mode, the bus is unused
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_sel_r <= `BC_RESET;
        end else if (wr_take && hit_bc &&
                     extended_memory_mode) begin
            wait_sel_r <= avs_writedata[`BC_WAIT_HI:`BC_WAIT_LO];
        end
    end

    // ==========================================================
    // program space routing
    main_state_t st_r;
    logic        in_flash;
    logic        in_space;
    logic        ext_start;
    logic        ext_done;
    logic        ext_busy;
    paddr_t      eff_addr;
    xaddr_t      ext_addr_nxt;
    word_t       ext_sync;

    // only program space is decoded; data ram never passes here
    assign in_flash = (fetch_addr < FLASH_TOP);
    assign in_space = (fetch_addr <= `PMEM_TOP);
    assign eff_addr = address_offset_enable ?
                      fetch_addr - FLASH_TOP : fetch_addr;
    // 16-bit parts are word addressed on the pins
    assign ext_addr_nxt = (data_width_select ?
                          eff_addr[20:1] : eff_addr[19:0]) &
                          width_mask(memory_mode_select);

    assign flash_rd   = (st_r == M_IDLE) & fetch_req & in_flash;
    assign flash_addr = fetch_addr;
    // external memory sits above flash
    assign ext_start  = (st_r == M_IDLE) & fetch_req & !in_flash &
                        in_space & extended_memory_mode;
    assign fetch_done = (st_r == M_RESP);

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= M_IDLE;
        end else begin
            unique case (st_r)
                M_IDLE: begin
                    if (flash_rd) begin
                        st_r <= M_FLASH;
                    end else if (ext_start) begin
                        st_r <= M_EXT;
                    end else if (fetch_req) begin
                        st_r <= M_RESP;
                    end
                end
                M_FLASH: st_r <= M_RESP;
                M_EXT: begin
                    if (ext_done) begin
                        st_r <= M_RESP;
                    end
                end
                M_RESP: st_r <= M_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fetch_rdata <= `NOP_WORD;
        end else if (st_r == M_IDLE && fetch_req && !flash_rd &&
                     !ext_start) begin
            // beyond flash in on-chip mode reads as a nop
            fetch_rdata <= `NOP_WORD;
        end else if (st_r == M_FLASH) begin
            fetch_rdata <= flash_rdata;
        end else if (st_r == M_EXT && ext_done) begin
            // 8-bit mode returns one byte per access only
            fetch_rdata <= data_width_select ? ext_sync :
                           {8'h00, ext_sync[7:0]};
        end
    end

    // ==========================================================
    // external bus pins
    logic wr_cyc_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            ext_addr <= '0;
        end else if (ext_start) begin
            ext_addr <= ext_addr_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ext_data_out <= '0;
        end else if (ext_start) begin
            ext_data_out <= fetch_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_cyc_r <= 1'b0;
        end else if (ext_start) begin
            wr_cyc_r <= fetch_write & fetch_table;
        end
    end

    // pins stay plain port pins in on-chip mode
    assign ext_bus_active = extended_memory_mode;
    assign ext_addr_oe    = (ext_busy && extended_memory_mode) ?
                            width_mask(memory_mode_select) : '0;
    assign ext_data_oe    = ext_busy & wr_cyc_r & extended_memory_mode;

    ext_bus_cycle #(
        .ACC (ACC),
        .TCY (TCY)
    ) u_cycle (
        .clk      (clk),
        .rst      (rst),
        .start    (ext_start),
        .table_op (fetch_table),
        .write_op (fetch_write & fetch_table),
        .wait_en  (wait_enable),
        .wait_sel (wait_sel_r),
        .busy     (ext_busy),
        .done     (ext_done),
        .ce_n     (ext_ce_n),
        .rd_n     (ext_rd_n),
        .wr_n     (ext_wr_n)
    );

    // external data is asynchronous to the core clock
    pin_sync #(
        .W (16)
    ) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (ext_data_in),
        .dout (ext_sync)
    );

    // ==========================================================
    // checks
    a_onchip_bus_idle: assert property (@(posedge clk) disable iff (rst)
        onchip_only_mode |-> ext_ce_n && ext_addr_oe == '0 && !ext_data_oe)
        else $error("external bus active in on-chip mode");
    a_small_pkg_mode: assert property (@(posedge clk) disable iff (rst)
        !large_r |-> onchip_only_mode && !ext_bus_active)
        else $error("small package left on-chip mode");
    a_zero_above_flash: assert property (@(posedge clk) disable iff (rst)
        (st_r == M_IDLE && fetch_req && !in_flash && onchip_only_mode)
        |=> fetch_done && fetch_rdata == `NOP_WORD)
        else $error("read above flash not zero");
    a_settings_frozen: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> $stable(cfg_act_r) && $stable(large_r))
        else $error("configuration changed after reset");
    a_cfg_low_zero: assert property (@(posedge clk) disable iff (rst)
        (avs_read && ack_r && hit_cfg) |-> avs_readdata[2:0] == 3'h0)
        else $error("unimplemented bits not zero");
    a_write_once: assert property (@(posedge clk) disable iff (rst)
        cfg_prog |=> !cfg_prog && prog_done_r)
        else $error("configuration programmed twice");
    a_width_mask: assert property (@(posedge clk) disable iff (rst)
        (!ext_ce_n && memory_mode_select == `MODE_A12)
        |-> ext_addr_oe == `MASK_A12 && ext_addr[19:12] == 8'h00)
        else $error("address width not honoured");
    a_flash_first: assert property (@(posedge clk) disable iff (rst)
        (fetch_req && st_r == M_IDLE && in_flash) |-> !ext_start ##2 fetch_done)
        else $error("flash address routed outside");
    a_byte_lane: assert property (@(posedge clk) disable iff (rst)
        (st_r == M_EXT && ext_done && !data_width_select)
        |=> fetch_rdata[15:8] == 8'h00)
        else $error("8-bit read filled the upper byte");
    a_shift_zero: assert property (@(posedge clk) disable iff (rst)
        (ext_start && address_offset_enable && fetch_addr == FLASH_TOP)
        |=> ext_addr == '0)
        else $error("shifted external space not at zero");
    a_bc_frozen: assert property (@(posedge clk) disable iff (rst)
        onchip_only_mode |-> $stable(wait_sel_r))
        else $error("bus control written in on-chip mode");
    c_onchip_nop: cover property (@(posedge clk) disable iff (rst)
        fetch_done && onchip_only_mode && !in_flash);
    c_ext_read: cover property (@(posedge clk) disable iff (rst)
        ext_done && !wr_cyc_r && address_offset_enable);
    c_cfg_prog: cover property (@(posedge clk) disable iff (rst)
        cfg_prog);
    c_byte_mode: cover property (@(posedge clk) disable iff (rst)
        fetch_done && extended_memory_mode && !data_width_select);
endmodule

/* File: dv/ext_mem_model.sv */
// external parallel program memory model for the memory mode bench
`timescale 1ns/1ps
module ext_mem_model (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            ce_n,
    input  wire logic            rd_n,
    input  wire logic            wr_n,
    input  wire pmm_pkg::xaddr_t addr,
    input  wire pmm_pkg::word_t  dout,
    input  wire logic            doe,
    output pmm_pkg::word_t       din,
    output logic                 sel_seen,
    output pmm_pkg::xaddr_t      cap_addr,
    output pmm_pkg::word_t       wr_last
);
    import pmm_pkg::*;
    // ==========================================================
    // read data lanes
    word_t last = 16'h0;
    // released pins show the inverse so stale data never looks valid
    assign din = (!ce_n && !rd_n) ? (addr[15:0] ^ 16'h3c5a) : ~last;
    always @(posedge clk) begin
        last <= din;
    end
    // ==========================================================
    // observation of bus use
    always @(posedge clk) begin
        if (rst) begin
            sel_seen <= 1'b0;
        end else if (!ce_n) begin
            sel_seen <= 1'b1;
            cap_addr <= addr;
        end
        if (!ce_n && !wr_n && doe) begin
            wr_last <= dout;
        end
    end
endmodule

/* File: dv/program_memory_mode_config_test.sv */
// self-checking bench for the program memory mode block
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module program_memory_mode_config_test;
    import pmm_pkg::*;
    typedef struct packed {
        cbyte_t c; logic lg; paddr_t a;
        logic ex; xaddr_t x; xaddr_t m; word_t d;
    } row_t;
    localparam paddr_t     FT  = 21'h010000;
    localparam logic [7:0] ACC = 8'h06;
    localparam int         TCY = 4;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        pkg_large = 1'b1;
    cbyte_t      cfg_nv = 8'hf8;
    logic        cfg_nv_locked = 1'b0;
    logic        cfg_prog;
    cbyte_t      cfg_prog_data;
    logic        fetch_req = 1'b0;
    logic        fetch_table = 1'b0;
    logic        fetch_write = 1'b0;
    paddr_t      fetch_addr = 21'h0;
    word_t       fetch_wdata = 16'h0;
    logic        fetch_done;
    word_t       fetch_rdata;
    logic        flash_rd;
    paddr_t      flash_addr;
    word_t       flash_rdata = 16'h0;
    logic        ext_bus_active;
    xaddr_t      ext_addr;
    xaddr_t      ext_addr_oe;
    xaddr_t      oe_seen;
    word_t       ext_data_out;
    logic        ext_data_oe;
    word_t       ext_data_in;
    logic        ext_ce_n;
    logic        ext_rd_n;
    logic        ext_wr_n;
    int          fails = 0;
    int          num_checks = 0;
    int          prog_cnt = 0;
    cbyte_t      prog_data;
    // inputs, then bus use, pin address, pin enables and returned word
    row_t        rows [7] = '{
        '{8'hff, 1'b1, 21'h000100, 1'b0, 20'h0, 20'h0, 16'h1334},
        '{8'hff, 1'b1, 21'h012000, 1'b0, 20'h0, 20'h0, 16'h0000},
        '{8'he8, 1'b1, 21'h012346, 1'b1, 20'h001a3, 20'h00fff, 16'h3df9},
        '{8'hd0, 1'b1, 21'h012346, 1'b1, 20'h091a3, 20'h0ffff, 16'hadf9},
        '{8'h80, 1'b1, 21'h1abcde, 1'b1, 20'habcde, 20'hfffff, 16'h0084},
        '{8'h80, 1'b0, 21'h1abcde, 1'b0, 20'h0, 20'h0, 16'h0000},
        '{8'hc8, 1'b1, 21'h00f000, 1'b0, 20'h0, 20'h0, 16'he234}};
    // ==========================================================
    // clock, flash and design
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        flash_rdata <= flash_addr[15:0] ^ 16'h1234;
        if (cfg_prog === 1'b1) begin
            prog_cnt++;
            prog_data = cfg_prog_data;
        end
        if (ext_ce_n === 1'b0)
            oe_seen <= ext_addr_oe;
    end
    program_memory_mode_config #(.FLASH_TOP(FT), .ACC(ACC),
        .TCY(8'(TCY))) dut_u (.clk(clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pkg_large(pkg_large), .cfg_nv(cfg_nv),
        .cfg_nv_locked(cfg_nv_locked), .cfg_prog(cfg_prog),
        .cfg_prog_data(cfg_prog_data), .fetch_req(fetch_req),
        .fetch_table(fetch_table), .fetch_write(fetch_write),
        .fetch_addr(fetch_addr), .fetch_wdata(fetch_wdata),
        .fetch_done(fetch_done), .fetch_rdata(fetch_rdata),
        .flash_rd(flash_rd), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata), .ext_bus_active(ext_bus_active),
        .ext_addr(ext_addr), .ext_addr_oe(ext_addr_oe),
        .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
        .ext_data_in(ext_data_in),
        .ext_ce_n(ext_ce_n), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n));
    ext_mem_model mem_u (.clk(clk), .rst(rst), .ce_n(ext_ce_n),
        .rd_n(ext_rd_n), .wr_n(ext_wr_n), .addr(ext_addr),
        .dout(ext_data_out), .doe(ext_data_oe), .din(ext_data_in),
        .sel_seen(), .cap_addr(), .wr_last());
    // ==========================================================
    // tasks
    task automatic results;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic do_reset(input cbyte_t c, input logic lg);
        @(posedge clk);
        cfg_nv <= c;
        pkg_large <= lg;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic av(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic fetch(input logic tb, input logic wr, input paddr_t a,
                         input word_t wd, output int n, output word_t q);
        @(posedge clk);
        fetch_req <= 1'b1;
        fetch_table <= tb;
        fetch_write <= wr;
        fetch_addr <= a;
        fetch_wdata <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (fetch_done !== 1'b1);
        q = fetch_rdata;
        fetch_req <= 1'b0;
    endtask
    // ==========================================================
    // watchdog and main sequence
    initial begin
        #200000;
        fails++;
        results();
    end
    initial begin
        logic [31:0] q;
        word_t       d;
        logic        onc;
        int          n0;
        int          n1;
        do_reset(8'hf8, 1'b1);
        foreach (rows[i]) begin
            do_reset(rows[i].c, rows[i].lg);
            onc = rows[i].c[5:4] == 2'b11 || !rows[i].lg;
            av(1'b0, 4'h0, 32'h0, q);
            `CHK(q, {24'h0, rows[i].c & 8'hf8})
            av(1'b0, 4'h8, 32'h0, q);
            `CHK(q & 32'hfb, {24'h0, rows[i].c[7:3], 1'b0, rows[i].lg, onc})
            `CHK(ext_bus_active, !onc)
            fetch(1'b0, 1'b0, rows[i].a, 16'h0, n0, d);
            `CHK(d, rows[i].d)
            `CHK(mem_u.sel_seen, rows[i].ex)
            if (rows[i].ex) begin
                `CHK(mem_u.cap_addr, rows[i].x)
                `CHK(oe_seen, rows[i].m)
            end
            cfg_nv <= ~rows[i].c;
            fetch(1'b0, 1'b0, rows[i].a, 16'h0, n0, d);
            `CHK(d, rows[i].d)
        end
        // on-chip mode refuses bus control writes, unmapped reads zero
        do_reset(8'hf8, 1'b1);
        `CHK({avs_readdata, fetch_rdata}, 48'h0)
        `CHK({cfg_prog, fetch_done, ext_ce_n, ext_data_oe}, 4'h2)
        av(1'b1, 4'h4, 32'h10, q);
        av(1'b0, 4'h4, 32'h0, q);
        `CHK(q, 32'h30)
        av(1'b0, 4'hc, 32'h0, q);
        `CHK(q, 32'h0)
        av(1'b1, 4'h0, 32'ha7, q);
        av(1'b1, 4'h0, 32'h55, q);
        av(1'b0, 4'h0, 32'h0, q);
        `CHK(prog_cnt, 1)
        `CHK(prog_data, 8'ha0)
        cfg_nv_locked <= 1'b1;
        do_reset(8'hf8, 1'b1);
        av(1'b1, 4'h0, 32'h07, q);
        av(1'b0, 4'h0, 32'h0, q);
        `CHK(prog_cnt, 1)
        cfg_nv_locked <= 1'b0;
        // wait states stretch table ops only, by whole instruction cycles
        do_reset(8'h40, 1'b1);
        fetch(1'b0, 1'b0, 21'h20000, 16'h0, n0, d);
        for (int s = 0; s < 4; s++) begin
            av(1'b1, 4'h4, 32'(s << 4), q);
            fetch(1'b1, 1'b0, 21'h20000, 16'h0, n1, d);
            `CHK(n1 - n0, s * TCY)
        end
        av(1'b0, 4'h4, 32'h0, q);
        `CHK(q, 32'h30)
        fetch(1'b1, 1'b1, 21'h20010, 16'hbeef, n1, d);
        `CHK(mem_u.wr_last, 16'hbeef)
        do_reset(8'hc8, 1'b1);
        fetch(1'b0, 1'b0, FT, 16'h0, n0, d);
        `CHK(mem_u.cap_addr, 20'h0)
        `CHK(d, 16'h3c5a)
        fetch(1'b1, 1'b0, FT, 16'h0, n1, d);
        `CHK(n1 - n0, 0)
        results();
    end
endmodule
